// File: rtl/bfs_defs.vh
// Constants for the buck fault supervisor
`ifndef BFS_DEFS_VH
`define BFS_DEFS_VH
`define BFS_CLK_HZ        50000000
`define BFS_BLANK_US      20480
`define BFS_BLANK_CYC     ((`BFS_BLANK_US * (`BFS_CLK_HZ / 1000000)))
`define BFS_OV_DELAY_NS   2000
`define BFS_OV_DELAY_CYC  ((`BFS_OV_DELAY_NS * (`BFS_CLK_HZ / 1000000)) / 1000)
`define BFS_SAMPLE_NS     40
`define BFS_SAMPLE_CYC    (((`BFS_SAMPLE_NS * (`BFS_CLK_HZ / 1000000)) + 999) / 1000)
`define BFS_FREQ_BASE_KHZ 300
`define BFS_FREQ_STEP_KHZ 100
`define BFS_FREQ_SETTINGS 10
`define BFS_DUTY_NUM      86
`define BFS_DUTY_DEN      100
`define BFS_SS_STEPS      16'h0100
`define BFS_LIM_FLOAT     2'h0
`define BFS_LIM_HIGH      2'h1
`define BFS_LIM_LOW       2'h2
`define BFS_LVL_FLOAT     3'h4
`define BFS_LVL_HIGH      3'h6
`define BFS_LVL_LOW       3'h2
`endif

// File: rtl/bfs_supervisor.v
// Buck fault supervisor: protection, sequencing and PWM timing
`timescale 1ns/1ps
`include "bfs_defs.vh"
module bfs_supervisor #(
    parameter BLANK_CYC   = `BFS_BLANK_CYC,
    parameter SS_STEPS    = `BFS_SS_STEPS
) (
    input  wire        core_clk,
    input  wire        reset,
    input  wire        enable_above_start,
    input  wire        enable_above_shutdown,
    input  wire        supply_valid,
    input  wire        bias_above_lockout,
    input  wire        thermal_trip_hot,
    input  wire        thermal_below_hyst,
    input  wire        sense_above_window_low,
    input  wire        sense_above_window_high,
    input  wire        sense_above_ov,
    input  wire [2:0]  valley_current_level,
    input  wire [3:0]  freq_select_strap,
    input  wire [1:0]  limit_select_strap,
    input  wire [7:0]  duty_demand,
    output reg         high_side_on,
    output reg         low_side_on,
    output reg         gate_tristate,
    output reg         output_in_window_flag_out,
    output reg         output_in_window_flag_oe,
    output reg         soft_start_restart,
    output reg         overcurrent_latch,
    output reg         overvoltage_guard,
    output reg         thermal_shutdown,
    output reg  [15:0] soft_start_level
);
    localparam ST_OFF   = 4'b0001;
    localparam ST_SOFT  = 4'b0010;
    localparam ST_RUN   = 4'b0100;
    localparam ST_BLANK = 4'b1000;
    localparam [3:0] FREQ_LAST = `BFS_FREQ_SETTINGS - 1;

    reg [3:0]  state_reg;
    reg [3:0]  state_next;
    reg [7:0]  phase_reg;
    reg [31:0] blank_reg;
    reg [7:0]  ov_cnt_reg;
    reg        ov_latch_reg;
    reg        oc_event;

    // Two-flop synchronisers for all analog comparator and strap inputs
    localparam SW = 24;
    wire [SW-1:0] raw_in = {enable_above_start, enable_above_shutdown, supply_valid,
        bias_above_lockout, thermal_trip_hot, thermal_below_hyst, sense_above_window_low,
        sense_above_window_high, sense_above_ov, valley_current_level, freq_select_strap,
        limit_select_strap, duty_demand[7:2]};
    reg [SW-1:0] meta_reg;
    reg [SW-1:0] sync_reg;
    always @(posedge core_clk) begin
        if (reset) begin
            meta_reg <= {SW{1'b0}};
            sync_reg <= {SW{1'b0}};
        end else begin
            meta_reg <= raw_in;
            sync_reg <= meta_reg;
        end
    end
    wire       en_start  = sync_reg[23];
    wire       en_shut   = sync_reg[22];
    wire       sup_ok    = sync_reg[21];
    wire       bias_ok   = sync_reg[20];
    wire       hot       = sync_reg[19];
    wire       cooled    = sync_reg[18];
    wire       win_lo    = sync_reg[17];
    wire       win_hi    = sync_reg[16];
    wire       ov_raw    = sync_reg[15];
    wire [2:0] cur_lvl   = sync_reg[14:12];
    wire [3:0] fsel      = sync_reg[11:8];
    wire [1:0] lsel      = sync_reg[7:6];
    wire [7:0] demand    = {sync_reg[5:0], 2'b00};

    // Period in core clocks for a frequency setting
    function [7:0] period_of;
        input [3:0] sel;
        reg   [3:0]  s;
        reg   [31:0] p;
        begin
            s = (sel > FREQ_LAST) ? FREQ_LAST : sel;
            p = `BFS_CLK_HZ / ((`BFS_FREQ_BASE_KHZ + `BFS_FREQ_STEP_KHZ * s) * 1000);
            period_of = p[7:0];
        end
    endfunction

    // Soft-start or run: switching allowed
    function is_active;
        input [3:0] st;
        begin
            is_active = (st == ST_SOFT) || (st == ST_RUN);
        end
    endfunction

    wire [7:0] period     = period_of(fsel);
    wire [31:0] max_on_w  = (period * `BFS_DUTY_NUM) / `BFS_DUTY_DEN;
    wire [7:0] max_on     = max_on_w[7:0];
    wire [15:0] dem_on_w  = (period * demand) >> 8;
    // Ramp scales the demanded on-time
    wire [31:0] ss_on_w   = (dem_on_w * soft_start_level) / SS_STEPS;
    wire [7:0] req_on     = (state_reg == ST_RUN) ? dem_on_w[7:0] : ss_on_w[7:0];
    wire [7:0] on_time    = (req_on > max_on) ? max_on : req_on;
    // sample window one eighth of a period before valley
    wire [7:0] sample_at  = period - (period >> 3);
    wire [2:0] limit      = (lsel == `BFS_LIM_HIGH) ? `BFS_LVL_HIGH :
                            (lsel == `BFS_LIM_LOW)  ? `BFS_LVL_LOW : `BFS_LVL_FLOAT;

    wire lockout = !(bias_ok && en_shut);
    wire in_sample = (phase_reg >= sample_at) &&
                     (phase_reg < sample_at + `BFS_SAMPLE_CYC);

    always @(posedge core_clk) begin
        if (reset) begin
            phase_reg <= 8'h00;
        end else if (phase_reg + 8'h01 >= period) begin
            phase_reg <= 8'h00;
        end else begin
            phase_reg <= phase_reg + 8'h01;
        end
    end

    always @* begin
        oc_event = is_active(state_reg) && low_side_on &&
                   in_sample && (cur_lvl > limit);
    end

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_OFF: begin
                // start on supply valid; restart after cooling; latch blocks
                if (sup_ok && !lockout && !ov_latch_reg && !thermal_shutdown)
                    state_next = ST_SOFT;
            end
            ST_SOFT: begin
                if (soft_start_level >= SS_STEPS)
                    state_next = ST_RUN;
            end
            ST_RUN: state_next = ST_RUN;
            ST_BLANK: begin
                if (blank_reg == 32'h0000_0000)
                    state_next = ST_OFF;
            end
            default: state_next = ST_OFF;
        endcase
        if (oc_event)
            state_next = ST_BLANK;
        if (hot || lockout || ov_latch_reg || !sup_ok)
            state_next = (state_next == ST_BLANK) ? ST_BLANK : ST_OFF;
    end

    always @(posedge core_clk) begin
        if (reset) begin
            state_reg <= ST_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    always @(posedge core_clk) begin
        if (reset) begin
            blank_reg         <= 32'h0000_0000;
            overcurrent_latch <= 1'b0;
        end else if (oc_event) begin
            blank_reg         <= BLANK_CYC;
            overcurrent_latch <= 1'b1;
        end else if (blank_reg != 32'h0000_0000) begin
            blank_reg <= blank_reg - 32'h0000_0001;
        end else begin
            overcurrent_latch <= 1'b0;
        end
    end

    always @(posedge core_clk) begin
        if (reset) begin
            thermal_shutdown <= 1'b0;
        end else if (hot) begin
            thermal_shutdown <= 1'b1;
        end else if (cooled) begin
            thermal_shutdown <= 1'b0;
        end
    end

    always @(posedge core_clk) begin
        if (reset) begin
            soft_start_level <= 16'h0000;
        end else if (!is_active(state_next)) begin
            soft_start_level <= 16'h0000;
        end else if (state_reg == ST_SOFT && phase_reg == 8'h00 &&
                     soft_start_level < SS_STEPS) begin
            soft_start_level <= soft_start_level + 16'h0001;
        end
    end

    always @(posedge core_clk) begin
        if (reset) begin
            soft_start_restart <= 1'b0;
        end else begin
            soft_start_restart <= (state_reg != ST_SOFT) && (state_next == ST_SOFT);
        end
    end

    // persistence reached; gated by enable start
    wire ov_fire = (ov_cnt_reg == `BFS_OV_DELAY_CYC - 1) && ov_raw && en_start;

    always @(posedge core_clk) begin
        if (reset) begin
            ov_cnt_reg        <= 8'h00;
            ov_latch_reg      <= 1'b0;
            overvoltage_guard <= 1'b0;
        end else begin
            if (ov_raw && en_start)
                ov_cnt_reg <= (ov_cnt_reg < `BFS_OV_DELAY_CYC) ? ov_cnt_reg + 8'h01 : ov_cnt_reg;
            else
                ov_cnt_reg <= 8'h00;
            if (ov_fire)
                ov_latch_reg <= 1'b1;
            else if (!bias_ok || !en_shut)
                ov_latch_reg <= 1'b0;
            overvoltage_guard <= ov_fire || (ov_latch_reg && bias_ok && en_shut);
        end
    end

    always @(posedge core_clk) begin
        if (reset) begin
            gate_tristate <= 1'b1;
        end else begin
            gate_tristate <= !en_shut;
        end
    end

    // Gate enables
    always @(posedge core_clk) begin
        if (reset) begin
            high_side_on <= 1'b0;
            low_side_on  <= 1'b0;
        end else if (lockout) begin
            high_side_on <= 1'b0;
            low_side_on  <= 1'b0;
        end else if (ov_latch_reg) begin
            // high-side off, low-side discharge while above threshold
            high_side_on <= 1'b0;
            low_side_on  <= ov_raw;
        end else if (is_active(state_next)) begin
            high_side_on <= (phase_reg < on_time);
            low_side_on  <= (phase_reg >= on_time) && (on_time != 8'h00);
        end else begin
            high_side_on <= 1'b0;
            low_side_on  <= 1'b0;
        end
    end

    always @(posedge core_clk) begin
        if (reset) begin
            output_in_window_flag_out <= 1'b0;
        end else begin
            output_in_window_flag_out <= 1'b0;
        end
    end

    always @(posedge core_clk) begin
        if (reset) begin
            output_in_window_flag_oe <= 1'b1;
        end else begin
            output_in_window_flag_oe <= !(win_lo && !win_hi && state_reg == ST_RUN &&
                                          !oc_event && !ov_latch_reg);
        end
    end
endmodule // bfs_supervisor

// File: test/bfs_supervisor_props.sv
// Assertion checker for the buck fault supervisor
`timescale 1ns/1ps
module bfs_supervisor_props #(
    parameter BLANK_CYC = 200
) (
    input wire core_clk,
    input wire reset,
    input wire enable_above_start,
    input wire bias_above_lockout,
    input wire sense_above_window_low,
    input wire sense_above_ov,
    input wire high_side_on,
    input wire low_side_on,
    input wire output_in_window_flag_out,
    input wire output_in_window_flag_oe,
    input wire overcurrent_latch,
    input wire overvoltage_guard,
    input wire thermal_shutdown
);
    reg [7:0]  ov_run_reg;
    reg [31:0] oc_run_reg;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    // Run lengths of the over-voltage input and the overcurrent latch
    always @(posedge core_clk) begin
        if (reset || !sense_above_ov) ov_run_reg <= 8'h00;
        else if (ov_run_reg != 8'hff) ov_run_reg <= ov_run_reg + 8'h01;
        if (reset || !overcurrent_latch) oc_run_reg <= 32'h0000_0000;
        else oc_run_reg <= oc_run_reg + 32'h0000_0001;
    end
    property p_oc_off;
        overcurrent_latch[*2] |-> !high_side_on && !low_side_on && output_in_window_flag_oe;
    endproperty
    a_oc_off: assert property (p_oc_off) else $error("gates on during blanking");
    property p_oc_blank;
        $fell(overcurrent_latch) |-> oc_run_reg >= BLANK_CYC - 2 && oc_run_reg <= BLANK_CYC + 4;
    endproperty
    a_oc_blank: assert property (p_oc_blank) else $error("blanking length wrong");
    property p_hot_off; thermal_shutdown[*2] |-> !high_side_on && !low_side_on; endproperty
    a_hot_off: assert property (p_hot_off) else $error("gates on while hot");
    property p_ov_hs; overvoltage_guard[*2] |-> !high_side_on && output_in_window_flag_oe; endproperty
    a_ov_hs: assert property (p_ov_hs) else $error("high side on in overvoltage");
    property p_ov_onset;
        $rose(overvoltage_guard) |-> ov_run_reg > 8'h5f && $past(enable_above_start, 4);
    endproperty
    a_ov_onset: assert property (p_ov_onset) else $error("overvoltage trip too early");
    property p_ls_off; (overvoltage_guard && !sense_above_ov)[*5] |-> !low_side_on; endproperty
    a_ls_off: assert property (p_ls_off) else $error("low side kept on");
    property p_lockout; (!bias_above_lockout)[*5] |-> !high_side_on && !low_side_on; endproperty
    a_lockout: assert property (p_lockout) else $error("gates on in lockout");
    property p_window; (!sense_above_window_low)[*5] |-> output_in_window_flag_oe; endproperty
    a_window: assert property (p_window) else $error("power-good high below window");
    property p_pg_od; output_in_window_flag_out == 1'b0; endproperty
    a_pg_od: assert property (p_pg_od) else $error("power-good driven high");
endmodule // bfs_supervisor_props
bind bfs_supervisor bfs_supervisor_props #(.BLANK_CYC(BLANK_CYC)) bfs_supervisor_props_inst (.*);

// File: test/bfs_stage_model.sv
// Output comparators and power-good pull-up around the supervisor
`timescale 1ns/1ps
module bfs_stage_model (
    input  wire [7:0] vout_pct,
    input  wire       pg_out,
    input  wire       pg_oe,
    output wire       win_low,
    output wire       win_high,
    output wire       ov_high,
    output wire       pg_pin
);
    assign win_low  = vout_pct > 8'h55;
    assign win_high = vout_pct > 8'h78;
    assign ov_high  = vout_pct > 8'h78;
    assign pg_pin   = pg_oe ? pg_out : 1'b1;
endmodule // bfs_stage_model

// File: test/buck_fault_supervisor_tb.sv
// Self-checking testbench for the buck fault supervisor
`timescale 1ns/1ps
module buck_fault_supervisor_tb;
    reg         core_clk, reset, enable_above_start, enable_above_shutdown, supply_valid;
    reg         bias_above_lockout, thermal_trip_hot, thermal_below_hyst;
    reg  [2:0]  valley_current_level;
    reg  [3:0]  freq_select_strap;
    reg  [1:0]  limit_select_strap;
    reg  [7:0]  duty_demand, vout_pct;
    wire        sense_above_window_low, sense_above_window_high, sense_above_ov, pg_pin;
    wire        high_side_on, low_side_on, gate_tristate, output_in_window_flag_out;
    wire        output_in_window_flag_oe, soft_start_restart, overcurrent_latch;
    wire        overvoltage_guard, thermal_shutdown;
    wire [15:0] soft_start_level;
    integer     num_errors, checks_done, cyc, n, i, e, on, per;
    time        t0;
    bfs_supervisor #(.BLANK_CYC(200), .SS_STEPS(16'h0004)) bfs_supervisor_inst (.*);
    bfs_stage_model bfs_stage_model_inst (.vout_pct(vout_pct), .pg_out(output_in_window_flag_out),
        .pg_oe(output_in_window_flag_oe), .win_low(sense_above_window_low),
        .win_high(sense_above_window_high), .ov_high(sense_above_ov), .pg_pin(pg_pin));
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (cyc == 40000) begin
            num_errors = num_errors + 1;
            give_verdict;
        end
    end
    task check(input [19:0] got, input [19:0] exp, input [63:0] what);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("mismatch %0s expected %0h seen %0h", what, exp, got);
            end
        end
    endtask
    task settle(input integer k); repeat (k) @(negedge core_clk); endtask
    task wait_hi(input integer s, input integer lim);
        begin
            n = 0;
            while (n < lim && (s == 0 ? soft_start_restart : s == 1 ? overcurrent_latch
                   : s == 2 ? overvoltage_guard : pg_pin) !== 1'b1) begin
                @(negedge core_clk);
                n = n + 1;
            end
        end
    endtask
    task give_verdict;
        begin
            if (num_errors == 0 && checks_done > 0) $display("TEST PASSED");
            else $display("TEST FAILED");
            $finish;
        end
    endtask
    task t_start;
        begin
            settle(6); check({gate_tristate, high_side_on, low_side_on}, 3'h4, "off");
            enable_above_shutdown = 1; enable_above_start = 1; bias_above_lockout = 1;
            supply_valid = 1; wait_hi(0, 50); check(n < 50, 1, "restart");
            wait_hi(3, 4000); check(pg_pin, 1, "pg up");
            vout_pct = 8'h50; settle(6); check(pg_pin, 0, "pg low");
            vout_pct = 8'h64; settle(6);
        end
    endtask
    task t_freq;
        for (i = 0; i < 10; i = i + 1) begin
            settle(1); freq_select_strap = i[3:0]; duty_demand = 8'hff; settle(400);
            @(posedge high_side_on) t0 = $time;
            @(negedge high_side_on) on = ($time - t0) / 20;
            @(posedge high_side_on) per = ($time - t0) / 20;
            e = 50000 / (300 + 100 * i);
            check(per >= e - 1 && per <= e + 1, 1, "period");
            check(on > 0 && on * 100 <= per * 86, 1, "duty");
        end
    endtask
    task t_oc(input [1:0] s, input [2:0] lim);
        begin
            @(negedge core_clk) limit_select_strap = s; valley_current_level = lim; settle(500);
            check(overcurrent_latch, 0, "at limit");
            valley_current_level = lim + 3'h1; wait_hi(1, 400); settle(2);
            check({overcurrent_latch, high_side_on, low_side_on, pg_pin}, 4'h8, "oc trip");
            valley_current_level = 3'h0; wait_hi(0, 300);
            check(n > 185 && n < 215, 1, "blanking");
            settle(2); check(overcurrent_latch, 0, "oc clear");
            wait_hi(3, 4000);
        end
    endtask
    task t_hot;
        begin
            thermal_trip_hot = 1; settle(6);
            check({thermal_shutdown, high_side_on, low_side_on, soft_start_level}, 19'h4_0000, "hot");
            thermal_trip_hot = 0; settle(20); check(thermal_shutdown, 1, "hyst");
            thermal_below_hyst = 1; wait_hi(0, 50); check(n < 50, 1, "cool");
            thermal_below_hyst = 0; wait_hi(3, 4000);
        end
    endtask
    task t_ov;
        begin
            enable_above_start = 0; vout_pct = 8'h82; settle(200);
            check(overvoltage_guard, 0, "ov early");
            vout_pct = 8'h64; enable_above_start = 1; settle(6);
            vout_pct = 8'h82; wait_hi(2, 150); check(n > 95 && n < 110, 1, "ov delay");
            settle(2); check({high_side_on, low_side_on, pg_pin}, 3'h2, "ov act");
            vout_pct = 8'h64; settle(6); check({overvoltage_guard, low_side_on}, 2'h2, "ov hold");
            enable_above_shutdown = 0; settle(6); check(gate_tristate, 1, "tristate");
            enable_above_shutdown = 1; settle(6); check(overvoltage_guard, 0, "ov clear");
        end
    endtask
    initial begin
        num_errors = 0; checks_done = 0; cyc = 0; reset = 1;
        enable_above_start = 0; enable_above_shutdown = 0; supply_valid = 0; bias_above_lockout = 0;
        thermal_trip_hot = 0; thermal_below_hyst = 0; valley_current_level = 3'h0;
        freq_select_strap = 4'h9; limit_select_strap = 2'h0; duty_demand = 8'h80; vout_pct = 8'h64;
        repeat (3) @(negedge core_clk);
        reset = 0;
        t_start; t_freq; t_oc(2'h0, 3'h4); t_oc(2'h1, 3'h6); t_oc(2'h2, 3'h2); t_hot; t_ov;
        give_verdict;
    end
endmodule // buck_fault_supervisor_tb
